/* File: rtl/opd_consts.vh */
// constants for the output driver pop-free sequencing register group
// durations are in units of 0.1 us at the nominal oscillator rate
`ifndef OPD_CONSTS_VH
`define OPD_CONSTS_VH

// register offsets (page already selected outside)
`define OPD_ADDR_POP      8'h21
`define OPD_ADDR_WAIT     8'h22
`define OPD_ADDR_ROUTE    8'h23

// reset values
`define OPD_RST_POP       8'h3e
`define OPD_RST_WAIT      8'h00
`define OPD_RST_ROUTE     8'h00

// field positions, pop removal register
`define OPD_POP_ORDER     7
`define OPD_POP_DLY_HI    6
`define OPD_POP_DLY_LO    3
`define OPD_POP_STEP_HI   2
`define OPD_POP_STEP_LO   1
`define OPD_POP_CM        0

// field positions, wait register
`define OPD_WAIT_HI       6
`define OPD_WAIT_LO       4

// field positions, routing register
`define OPD_RT_DACL_HI    7
`define OPD_RT_DACL_LO    6
`define OPD_RT_MICL_LM    5
`define OPD_RT_MICR_LM    4
`define OPD_RT_DACR_HI    3
`define OPD_RT_DACR_LO    2
`define OPD_RT_MICR_RM    1
`define OPD_RT_DIFF       0

// routing codes
`define OPD_ROUTE_MIXER   2'h1
`define OPD_ROUTE_DIRECT  2'h2

// nominal oscillator rate in kHz and time unit divisor (0.1 us)
`define OPD_OSC_KHZ       64'd8200
`define OPD_UNIT_DIV      64'd10000

// driver power-on times, 0.1 us units
`define OPD_PON_T0        64'd0
`define OPD_PON_T1        64'd153
`define OPD_PON_T3        64'd15300
`define OPD_PON_T4        64'd153000
`define OPD_PON_T5        64'd762000
`define OPD_PON_T6        64'd1530000
`define OPD_PON_T7        64'd3040000
`define OPD_PON_T8        64'd6100000
`define OPD_PON_T9        64'd30400000
`define OPD_PON_T11       64'd61000000

// ramp-up step times, 0.1 us units
`define OPD_STEP_T1       64'd9800
`define OPD_STEP_T2       64'd19500
`define OPD_STEP_T3       64'd39000

// speaker power-up wait times, 0.1 us units
`define OPD_SPK_T1        64'd30400
`define OPD_SPK_T2        64'd76200
`define OPD_SPK_T3        64'd122000
`define OPD_SPK_T4        64'd153000
`define OPD_SPK_T5        64'd198000
`define OPD_SPK_T6        64'd244000
`define OPD_SPK_T7        64'd305000

`endif

/* File: rtl/opd_output_driver.v */
// register group and power sequencer for headphone and speaker drivers
// assumes register port is page-qualified outside; oscTick is the oscillator rate as an enable
`timescale 1ns/1ps
`include "opd_consts.vh"

// Summary of operation
// - order clear: DAC off with amplifiers
// - order set: DAC off after amplifiers off
// - four-bit power-on delay, reset 0111
// - durations scale with real oscillator rate
// - two-bit ramp step time, reset 11
// - common-mode from supply divider when zero
// - three-bit speaker wait, reset 000
// - left converter routing select
// - left mic to left mixer
// - right mic to left mixer
// - right converter routing select
// - right mic to right mixer
// - left headphone feeds right for differential
// - headphone power bits start delay and ramp
module opd_output_driver #(
    parameter [63:0] OSC_KHZ = `OPD_OSC_KHZ,
    parameter        TW      = 26
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // register port
    input  wire [7:0] regAddr,
    input  wire       regWrEn,
    input  wire [7:0] regWrData,
    input  wire       regRdEn,
    output reg  [7:0] regRdData,
    // oscillator and power requests
    input  wire       oscTick,
    input  wire       hpLeftPowerReq,
    input  wire       hpRightPowerReq,
    input  wire       spkPowerReq,
    input  wire       dacPowerReq,
    input  wire       swPowerDown,
    input  wire       gainApplied,
    input  wire       ampsOff,
    // driver control
    output reg        hpLeftPowerOn,
    output reg        hpRightPowerOn,
    output reg        hpRampStep,
    output reg        spkPowerOn,
    output reg        dacPowerOn,
    output reg        cmFromDivider,
    // routing
    output reg        dacLeftToMixer,
    output reg        dacLeftToHp,
    output reg        micLeftToLeftMixer,
    output reg        micRightToLeftMixer,
    output reg        dacRightToMixer,
    output reg        dacRightToHp,
    output reg        micRightToRightMixer,
    output reg        hpLeftToRightDiff
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_RAMP  = 2'h2;
    localparam [1:0] ST_ON    = 2'h3;
    reg  [7:0]    popReg;
    reg  [7:0]    waitReg;
    reg  [7:0]    routeReg;
    reg  [1:0]    state;
    reg  [1:0]    next_state;
    reg           podStart;
    reg           stepStart;
    reg           spkStart;
    reg           spkReqLast;
    wire          podDone;
    wire          stepDone;
    wire          spkDone;
    wire          spkBusy;
    wire          anyHpReq = hpLeftPowerReq | hpRightPowerReq;

    // oscillator ticks for a time in 0.1 us, rounded up so the duration is met
    function [TW-1:0] ticks;
        input [63:0] t;
        reg   [63:0] n;
        begin
            n     = (t * OSC_KHZ + `OPD_UNIT_DIV - 64'd1) / `OPD_UNIT_DIV;
            ticks = n[TW-1:0];
        end
    endfunction
    function [TW-1:0] ponTicks;
        input [3:0] code;
        begin
            case (code)
                4'h0:    ponTicks = ticks(`OPD_PON_T0);
                4'h1:    ponTicks = ticks(`OPD_PON_T1);
                4'h2:    ponTicks = ticks(`OPD_PON_T1);
                4'h3:    ponTicks = ticks(`OPD_PON_T3);
                4'h4:    ponTicks = ticks(`OPD_PON_T4);
                4'h5:    ponTicks = ticks(`OPD_PON_T5);
                4'h6:    ponTicks = ticks(`OPD_PON_T6);
                4'h7:    ponTicks = ticks(`OPD_PON_T7);
                4'h8:    ponTicks = ticks(`OPD_PON_T8);
                4'h9:    ponTicks = ticks(`OPD_PON_T9);
                4'ha:    ponTicks = ticks(`OPD_PON_T9);
                default: ponTicks = ticks(`OPD_PON_T11);
            endcase
        end
    endfunction

    function [TW-1:0] stepTicks;
        input [1:0] code;
        begin
            case (code)
                2'h1:    stepTicks = ticks(`OPD_STEP_T1);
                2'h2:    stepTicks = ticks(`OPD_STEP_T2);
                2'h3:    stepTicks = ticks(`OPD_STEP_T3);
                default: stepTicks = {TW{1'b0}};
            endcase
        end
    endfunction

    // printed table repeats two codes; taken as ascending order of codes
    function [TW-1:0] spkTicks;
        input [2:0] code;
        begin
            case (code)
                3'h1:    spkTicks = ticks(`OPD_SPK_T1);
                3'h2:    spkTicks = ticks(`OPD_SPK_T2);
                3'h3:    spkTicks = ticks(`OPD_SPK_T3);
                3'h4:    spkTicks = ticks(`OPD_SPK_T4);
                3'h5:    spkTicks = ticks(`OPD_SPK_T5);
                3'h6:    spkTicks = ticks(`OPD_SPK_T6);
                3'h7:    spkTicks = ticks(`OPD_SPK_T7);
                default: spkTicks = {TW{1'b0}};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file; reserved bits are stored as written
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            popReg    <= `OPD_RST_POP;
            waitReg   <= `OPD_RST_WAIT;
            routeReg  <= `OPD_RST_ROUTE;
            regRdData <= 8'h00;
        end else begin
            if (regWrEn) begin
                case (regAddr)
                    `OPD_ADDR_POP:   popReg   <= regWrData;
                    `OPD_ADDR_WAIT:  waitReg  <= regWrData;
                    `OPD_ADDR_ROUTE: routeReg <= regWrData;
                    default:         ;
                endcase
            end
            if (regRdEn) begin
                case (regAddr)
                    `OPD_ADDR_POP:   regRdData <= popReg;
                    `OPD_ADDR_WAIT:  regRdData <= waitReg;
                    `OPD_ADDR_ROUTE: regRdData <= routeReg;
                    default:         regRdData <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing and common-mode decode; reserved route code 11 drives nothing
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmFromDivider        <= 1'b1;
            dacLeftToMixer       <= 1'b0;
            dacLeftToHp          <= 1'b0;
            micLeftToLeftMixer   <= 1'b0;
            micRightToLeftMixer  <= 1'b0;
            dacRightToMixer      <= 1'b0;
            dacRightToHp         <= 1'b0;
            micRightToRightMixer <= 1'b0;
            hpLeftToRightDiff    <= 1'b0;
        end else begin
            cmFromDivider        <= ~popReg[`OPD_POP_CM];
            dacLeftToMixer       <= routeReg[`OPD_RT_DACL_HI:`OPD_RT_DACL_LO] == `OPD_ROUTE_MIXER;
            dacLeftToHp          <= routeReg[`OPD_RT_DACL_HI:`OPD_RT_DACL_LO] == `OPD_ROUTE_DIRECT;
            micLeftToLeftMixer   <= routeReg[`OPD_RT_MICL_LM];
            micRightToLeftMixer  <= routeReg[`OPD_RT_MICR_LM];
            dacRightToMixer      <= routeReg[`OPD_RT_DACR_HI:`OPD_RT_DACR_LO] == `OPD_ROUTE_MIXER;
            dacRightToHp         <= routeReg[`OPD_RT_DACR_HI:`OPD_RT_DACR_LO] == `OPD_ROUTE_DIRECT;
            micRightToRightMixer <= routeReg[`OPD_RT_MICR_RM];
            hpLeftToRightDiff    <= routeReg[`OPD_RT_DIFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers; all count oscillator ticks so durations follow its real rate
    opd_timer #(.W(TW)) podTimer (
        .clk     (clk),
        .rst     (rst),
        .start   (podStart),
        .count   (ponTicks(popReg[`OPD_POP_DLY_HI:`OPD_POP_DLY_LO])),
        .oscTick (oscTick),
        .busy    (),
        .done    (podDone)
    );
    opd_timer #(.W(TW)) stepTimer (
        .clk     (clk),
        .rst     (rst),
        .start   (stepStart),
        .count   (stepTicks(popReg[`OPD_POP_STEP_HI:`OPD_POP_STEP_LO])),
        .oscTick (oscTick),
        .busy    (),
        .done    (stepDone)
    );
    opd_timer #(.W(TW)) spkTimer (
        .clk     (clk),
        .rst     (rst),
        .start   (spkStart),
        .count   (spkTicks(waitReg[`OPD_WAIT_HI:`OPD_WAIT_LO])),
        .oscTick (oscTick),
        .busy    (spkBusy),
        .done    (spkDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // headphone sequence: power-on delay, then gain ramp steps until applied
    always @* begin
        next_state = state;
        podStart   = 1'b0;
        stepStart  = 1'b0;
        if (swPowerDown || !anyHpReq) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    podStart   = 1'b1;
                    next_state = ST_DELAY;
                end
                ST_DELAY: begin
                    if (podDone) begin
                        stepStart  = 1'b1;
                        next_state = ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    if (gainApplied) begin
                        next_state = ST_ON;
                    end else if (stepDone) begin
                        stepStart = 1'b1;
                    end
                end
                ST_ON:   next_state = ST_ON;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= ST_IDLE;
            hpLeftPowerOn  <= 1'b0;
            hpRightPowerOn <= 1'b0;
            hpRampStep     <= 1'b0;
        end else begin
            state          <= next_state;
            hpRampStep     <= (state == ST_RAMP) && stepDone && !swPowerDown && anyHpReq;
            hpLeftPowerOn  <= hpLeftPowerReq && !swPowerDown && (next_state == ST_RAMP || next_state == ST_ON);
            hpRightPowerOn <= hpRightPowerReq && !swPowerDown && (next_state == ST_RAMP || next_state == ST_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // speaker wait and converter power-down ordering
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            spkReqLast <= 1'b0;
            spkStart   <= 1'b0;
            spkPowerOn <= 1'b0;
            dacPowerOn <= 1'b0;
        end else begin
            spkReqLast <= spkPowerReq;
            spkStart   <= spkPowerReq && !spkReqLast && !swPowerDown;
            if (swPowerDown || !spkPowerReq) begin
                spkPowerOn <= 1'b0;
            end else if (spkDone && !spkBusy) begin
                spkPowerOn <= 1'b1;
            end
            if (!swPowerDown) begin
                dacPowerOn <= dacPowerReq;
            end else if (!popReg[`OPD_POP_ORDER] || ampsOff) begin
                dacPowerOn <= 1'b0;
            end
        end
    end

endmodule

/* File: rtl/opd_timer.v */
// down-counter of oscillator ticks with a done pulse
// assumes oscTick is a one-cycle enable synchronous to clk
`timescale 1ns/1ps
module opd_timer #(
    parameter W = 26
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // control
    input  wire         start,
    input  wire [W-1:0] count,
    input  wire         oscTick,
    // status
    output reg          busy,
    output reg          done
);

    reg [W-1:0] remain;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= {W{1'b0}};
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remain <= count;
                busy   <= 1'b1;
            end else if (busy) begin
                if (remain == {W{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else if (oscTick) begin
                    remain <= remain - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

/* File: tb/opd_analog_model.sv */
// behavioural analog side: oscillator, gain ramp status, amplifier off status
// assumes driver controls are registered outputs of the design
`timescale 1ns/1ps
module opd_analog_model #(
    parameter OSC_DIV = 4,
    parameter AMP_LAG = 10,
    parameter STEPS   = 3
) (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // driver controls
    input  wire hpLeftPowerOn,
    input  wire hpRightPowerOn,
    input  wire spkPowerOn,
    input  wire hpRampStep,
    // analog status
    output reg  oscTick,
    output reg  gainApplied,
    output reg  ampsOff
);
    reg [3:0] div;
    reg [3:0] steps;
    reg [7:0] lag;
    wire      hpOn = hpLeftPowerOn | hpRightPowerOn;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div         <= 4'h0;
            oscTick     <= 1'b0;
            steps       <= 4'h0;
            gainApplied <= 1'b0;
            lag         <= 8'h00;
            ampsOff     <= 1'b0;
        end else begin
            // oscillator slower than clk, so durations scale with it
            div     <= (div == OSC_DIV - 1) ? 4'h0 : div + 4'h1;
            oscTick <= (div == 4'h0);
            steps   <= !hpOn ? 4'h0 : steps + {3'h0, hpRampStep};
            gainApplied <= hpOn && steps >= STEPS;
            // amplifiers settle slowly, so the converter must wait
            lag     <= (hpOn | spkPowerOn) ? 8'h00 : (lag == AMP_LAG ? lag : lag + 8'h01);
            ampsOff <= lag == AMP_LAG;
        end
    end
endmodule

/* File: tb/opd_output_driver_properties.sv */
// checker for the output driver register group
// assumes bind to opd_output_driver, one clock domain
`timescale 1ns/1ps
module opd_output_driver_properties (
    // clock and reset
    input wire       clk,
    input wire       rst,
    // register port and requests
    input wire [7:0] regAddr,
    input wire       regWrEn,
    input wire [7:0] regWrData,
    input wire       hpLeftPowerReq,
    input wire       hpRightPowerReq,
    input wire       gainApplied,
    input wire       dacPowerReq,
    input wire       swPowerDown,
    input wire       ampsOff,
    // outputs
    input wire       hpLeftPowerOn,
    input wire       hpRightPowerOn,
    input wire       hpRampStep,
    input wire       spkPowerOn,
    input wire       dacPowerOn,
    input wire       cmFromDivider,
    input wire       dacLeftToMixer,
    input wire       dacLeftToHp,
    input wire       micLeftToLeftMixer,
    input wire       micRightToLeftMixer,
    input wire       dacRightToMixer,
    input wire       dacRightToHp,
    input wire       micRightToRightMixer,
    input wire       hpLeftToRightDiff
);
    // shadow copies follow every write to 0x21 and 0x23, other offsets ignored
    reg [7:0] popW;
    reg [7:0] rtW;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            popW <= 8'h3e;
            rtW  <= 8'h00;
        end else if (regWrEn) begin
            if (regAddr == 8'h21)
                popW <= regWrData;
            if (regAddr == 8'h23)
                rtW <= regWrData;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_left_mix: assert property (dacLeftToMixer == $past(rtW[7:6] == 2'h1))
        else $error("left mixer path wrong");
    a_left_direct: assert property (dacLeftToHp == $past(rtW[7:6] == 2'h2))
        else $error("left direct path wrong");
    a_right_route: assert property ({dacRightToMixer, dacRightToHp} ==
        $past({rtW[3:2] == 2'h1, rtW[3:2] == 2'h2})) else $error("right path wrong");
    a_mic_paths: assert property ({micLeftToLeftMixer, micRightToLeftMixer,
        micRightToRightMixer} == $past({rtW[5], rtW[4], rtW[1]})) else $error("mic path wrong");
    a_diff_feed: assert property (hpLeftToRightDiff == $past(rtW[0]))
        else $error("differential feed wrong");
    a_cm_source: assert property (popW == $past(popW) |-> cmFromDivider == !popW[0])
        else $error("common-mode source wrong");
    a_dac_with_amps: assert property (swPowerDown && !popW[7] |=> !dacPowerOn)
        else $error("converter not off with amplifiers");
    a_dac_after_amps: assert property (swPowerDown && popW[7] && !ampsOff && dacPowerOn
        && dacPowerReq |=> dacPowerOn) else $error("converter off before amplifiers");
    a_hp_gate: assert property (!hpLeftPowerReq |=> !hpLeftPowerOn)
        else $error("left driver on without request");
    a_hp_right_gate: assert property (!hpRightPowerReq |=> !hpRightPowerOn)
        else $error("right driver on without request");
    a_ramp_stops: assert property (gainApplied && $past(gainApplied) |=> !hpRampStep)
        else $error("ramp step after gain applied");
    a_pd_clears: assert property (swPowerDown |=> !(hpLeftPowerOn || hpRightPowerOn || spkPowerOn))
        else $error("driver on during power-down");
    c_dac_late: cover property (swPowerDown && popW[7] && ampsOff && dacPowerOn);
    c_hp_on: cover property ($rose(hpLeftPowerOn));
    c_spk_on: cover property ($rose(spkPowerOn));
    c_ramp_done: cover property (gainApplied && hpLeftPowerOn);
endmodule
bind opd_output_driver opd_output_driver_properties u_props (.*);

/* File: tb/tb_top.sv */
// self-checking bench for the output driver register group
// assumes the analog model answers with a four-cycle oscillator tick
`timescale 1ns/1ps
module tb_top;
    localparam P = 4;
    typedef struct {bit [3:0] pc; bit [1:0] st; bit [2:0] sp; int pt; int stt; int spt;} opd_row_t;
    typedef struct {bit [7:0] a; bit [7:0] d; bit [7:0] er; bit [7:0] ex;} opd_rt_t;
    // timing rows with tick counts at a 1 kHz nominal rate
    opd_row_t rows[5] = '{'{0, 0, 0, 0, 0, 0}, '{1, 1, 1, 1, 1, 4}, '{3, 2, 3, 2, 2, 13},
                          '{7, 3, 5, 304, 4, 20}, '{10, 1, 7, 3040, 1, 31}};
    opd_rt_t rt[7] = '{'{8'h23, 8'h55, 8'h55, 8'h99}, '{8'h23, 8'haa, 8'haa, 8'h66},
                       '{8'h24, 8'hff, 8'h00, 8'h66}, '{8'h23, 8'hff, 8'hff, 8'h33},
                       '{8'h23, 8'h00, 8'h00, 8'h00}, '{8'h23, 8'h61, 8'h61, 8'ha1},
                       '{8'h23, 8'h98, 8'h98, 8'h54}};
    logic       clk, rst, regWrEn, regRdEn, hpLeftPowerReq, hpRightPowerReq, spkPowerReq, dacPowerReq, swPowerDown;
    logic [7:0] regAddr, regWrData, regRdData, v;
    wire        oscTick, gainApplied, ampsOff, hpLeftPowerOn, hpRightPowerOn, hpRampStep;
    wire        spkPowerOn, dacPowerOn, cmFromDivider;
    wire  [7:0] route;
    wire  [2:0] sig = {hpRampStep, spkPowerOn, hpLeftPowerOn};
    int         nMismatch, samplesChecked, n;
    ////////////////////////////////////////
    opd_output_driver #(.OSC_KHZ(64'd1), .TW(26)) u_dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .oscTick(oscTick), .hpLeftPowerReq(hpLeftPowerReq), .hpRightPowerReq(hpRightPowerReq),
        .spkPowerReq(spkPowerReq), .dacPowerReq(dacPowerReq), .swPowerDown(swPowerDown),
        .gainApplied(gainApplied), .ampsOff(ampsOff), .hpLeftPowerOn(hpLeftPowerOn),
        .hpRightPowerOn(hpRightPowerOn), .hpRampStep(hpRampStep), .spkPowerOn(spkPowerOn),
        .dacPowerOn(dacPowerOn), .cmFromDivider(cmFromDivider), .dacLeftToMixer(route[7]),
        .dacLeftToHp(route[6]), .micLeftToLeftMixer(route[5]), .micRightToLeftMixer(route[4]),
        .dacRightToMixer(route[3]), .dacRightToHp(route[2]), .micRightToRightMixer(route[1]),
        .hpLeftToRightDiff(route[0]));
    opd_analog_model #(.OSC_DIV(P), .AMP_LAG(10), .STEPS(3)) u_ana (.clk(clk), .rst(rst),
        .hpLeftPowerOn(hpLeftPowerOn), .hpRightPowerOn(hpRightPowerOn), .spkPowerOn(spkPowerOn),
        .hpRampStep(hpRampStep), .oscTick(oscTick), .gainApplied(gainApplied), .ampsOff(ampsOff));
    ////////////////////////////////////////
    task testDone;
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        samplesChecked++;
        if (s !== e) begin
            nMismatch++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        d = regRdData;
    endtask
    // bounded wait; a hang ends the run as a failure
    task wh(input int s, output int k);
        k = 0;
        while (sig[s] !== 1'b1) begin
            @(negedge clk);
            k++;
            if (k > 30000) begin
                nMismatch++;
                testDone();
            end
        end
    endtask
    // first tick may land up to one period early
    task rng(input int k, input int t);
        chk({7'h0, k >= (t > 0 ? (t - 1) * P : 0) && k <= t * P + 8}, 8'h01);
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, regWrEn, regRdEn, hpLeftPowerReq, hpRightPowerReq, spkPowerReq, dacPowerReq, swPowerDown} = 8'h80;
        regAddr = 8'h00;
        regWrData = 8'h00;
        nMismatch = 0;
        samplesChecked = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(8'h21, v);
        chk(v, 8'h3e);
        rd(8'h22, v);
        chk(v, 8'h00);
        chk({7'h0, cmFromDivider}, 8'h01);
        foreach (rt[i]) begin
            wr(rt[i].a, rt[i].d);
            @(negedge clk);
            rd(rt[i].a, v);
            chk(v, rt[i].er);
            chk(route, rt[i].ex);
        end
        foreach (rows[i]) begin
            wr(8'h21, {1'b0, rows[i].pc, rows[i].st, 1'b0});
            wr(8'h22, {1'b0, rows[i].sp, 4'h0});
            hpLeftPowerReq = 1'b1;
            hpRightPowerReq = rows[i].pc[0];
            wh(0, n);
            rng(n, rows[i].pt);
            chk({7'h0, hpRightPowerOn}, {7'h0, rows[i].pc[0]});
            wh(2, n);
            @(negedge clk);
            wh(2, n);
            rng(n + 1, rows[i].stt);
            // by now all gain is applied: left driver stays on, no more ramp steps
            repeat (40) @(negedge clk);
            chk({6'h0, hpLeftPowerOn, hpRampStep}, 8'h02);
            hpLeftPowerReq = 1'b0;
            hpRightPowerReq = 1'b0;
            spkPowerReq = 1'b1;
            wh(1, n);
            rng(n, rows[i].spt);
            spkPowerReq = 1'b0;
            repeat (2) @(negedge clk);
            chk({5'h0, hpRightPowerOn, hpLeftPowerOn, spkPowerOn}, 8'h00);
        end
        for (int o = 0; o < 2; o++) begin
            wr(8'h21, {o[0], 7'h3e});
            wr(8'h22, 8'h00);
            dacPowerReq = 1'b1;
            spkPowerReq = 1'b1;
            wh(1, n);
            chk({7'h0, dacPowerOn}, 8'h01);
            // amplifier-off status rises eleven clocks after the speaker enable falls
            repeat (2) @(negedge clk);
            swPowerDown = 1'b1;
            repeat (3) @(negedge clk);
            chk({7'h0, dacPowerOn}, {7'h0, o[0]});
            repeat (14) @(negedge clk);
            chk({7'h0, dacPowerOn}, 8'h00);
            spkPowerReq = 1'b0;
            dacPowerReq = 1'b0;
            @(negedge clk);
            swPowerDown = 1'b0;
        end
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(8'h23, v);
        chk(v, 8'h00);
        chk(route, 8'h00);
        rd(8'h21, v);
        chk(v, 8'h3e);
        testDone();
    end
endmodule
